//--- ipi_consts.svh
// constants for the input program interface: codes, decoder contents, offsets, reset values, rate multiplier
// Contract
// RULE1 - remote select disables front panel switches
// RULE2 - remote select enables relay output buffers
// RULE3 - host raises interface reset on character P
// RULE4 - reset clears both channel latches, non-DAC mode
// RULE5 - non-DAC strobes reach only control latches
// RULE6 - select lines choose channel A or B
// RULE7 - host holds select lines until next prefix
// RULE8 - controls keep defaults until programmed
// RULE9 - decoder maps code 0111 to 000011
// RULE10 - channel B uses same decoder as A
// RULE11 - level command is prefix, sign, X.YZ, asterisk
// RULE12 - sign in non-DAC sets DAC bit, rising edge
// RULE13 - DAC bit alters decode, strobes to shifter
// RULE14 - sign shifted in on same strobe falling edge
// RULE15 - DAC mode never clocks control latches
// RULE16 - decimal point strobe suppressed, not stored
// RULE17 - asterisk blocked, falling edge clears DAC bit
// RULE18 - stored sign and digits held static
// RULE19 - rate multiplier gives N pulses per 1000
// RULE20 - pulses resynchronised on inverted oscillator, q and q_n
// RULE21 - plus sign selects negative current source
// RULE22 - non-DAC for conditioning, DAC for levels only
// RULE23 - code and selects stable over whole strobe
`ifndef IPI_CONSTS_SVH
`define IPI_CONSTS_SVH

// character codes on the nibble, bit 0 is the first data line
`define IPI_CODE_PLUS    4'hB
`define IPI_CODE_MINUS   4'hD
`define IPI_CODE_POINT   4'hE
`define IPI_CODE_STAR    4'hA
`define IPI_CODE_W       4
`define IPI_WORD_W       6

// decoder contents, entry 15 first; non-DAC and DAC address halves
`define IPI_ROM_NDAC {6'h10,6'h10,6'h0F,6'h10,6'h0F,6'h10,6'h0B,6'h0A,6'h03,6'h02,6'h09,6'h08,6'h07,6'h06,6'h05,6'h04}
`define IPI_ROM_DAC  {6'h10,6'h10,6'h00,6'h10,6'h00,6'h30,6'h00,6'h00,6'h00,6'h00,6'h00,6'h00,6'h00,6'h00,6'h00,6'h00}

// latch layout
`define IPI_LATCH_RST    8'h00
`define IPI_DAC_BIT      7
`define IPI_SHIFT_RST    16'h0000
`define IPI_SIGN_HI      15
`define IPI_SIGN_LO      12

// rate multiplier
`define IPI_RM_MOD       11'd1000
`define IPI_BCD_HUND     10'd100
`define IPI_BCD_TEN      10'd10

// register byte offsets
`define IPI_REG_CTRL     8'h00
`define IPI_REG_STATUS   8'h04
`define IPI_REG_LATCH    8'h08
`define IPI_REG_LEVEL_A  8'h0C
`define IPI_REG_LEVEL_B  8'h10
`define IPI_CTRL_RST     2'h1
`define IPI_CTRL_RUN     0
`define IPI_CTRL_SRST    1
`define IPI_CHAN_A       0
`define IPI_CHAN_B       1

`endif

//--- ipi_pkg.sv
// types shared by the input program interface
package ipi_pkg;

    // one decoder output word
    typedef struct packed {
        logic       level_end;  // asterisk: leave DAC mode
        logic       block;      // suppress the strobe
        logic [2:0] addr;       // latch bit address
        logic       data;       // value latched
    } ipi_word_t;

    // analog-side drive of one trigger level channel
    typedef struct packed {
        logic pos_src_en;       // positive current source enable
        logic neg_src_en;       // negative current source enable
        logic pulse_q;          // resynchronised pulse, true
        logic pulse_q_n;        // resynchronised pulse, complement
    } ipi_chan_t;

endpackage : ipi_pkg

//--- ipi_input_prog.sv
// remote programming interface for the two counter input channels
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
`include "ipi_consts.svh"

module ipi_input_prog #(
    parameter int NCH = 2                                 // channels
) (
    input  wire logic                     hclk,           // bus clock, 10 MHz
    input  wire logic                     hresetn,        // async reset, low
    input  wire logic                     hsel,           // slave select
    input  wire logic [31:0]              haddr,          // byte address
    input  wire logic [1:0]               htrans,         // transfer type
    input  wire logic                     hwrite,         // write when high
    input  wire logic [2:0]               hsize,          // word only
    input  wire logic [31:0]              hwdata,         // write data
    input  wire logic                     hready,         // bus ready
    output logic                          hreadyout,      // slave ready
    output logic                          hresp,          // always okay
    output logic [31:0]                   hrdata,         // read data
    input  wire logic                     remote_select_n,// remote, low
    input  wire logic                     interface_reset,// host reset, high
    input  wire logic                     char_strobe,    // character clock
    input  wire logic                     chan_sel_a,     // channel A select
    input  wire logic                     chan_sel_b,     // channel B select
    input  wire logic [3:0]               char_code_nibble, // character code
    input  wire logic                     rm_osc,         // rate multiplier osc
    output logic                          local_sw_disable, // panel lockout
    output logic                          relay_oe_n,     // relay buffer enable, low
    output logic [1:0][6:0]               relay_ctrl,     // relay drive per channel
    output logic                          dac_mode,       // DAC control mode
    output ipi_pkg::ipi_chan_t [1:0]      dac_out         // level drive per channel
);
    import ipi_pkg::*;

    // complete block state, registered as one
    typedef struct packed {
        logic                  strb_s1;     // strobe sync stage 1
        logic                  strb_s2;     // strobe sync stage 2
        logic                  strb_d;      // strobe delayed, edge find
        logic [1:0]            sel_s1;      // selects stage 1
        logic [1:0]            sel_s2;      // selects stage 2
        logic [3:0]            code_s1;     // code stage 1
        logic [3:0]            code_s2;     // code stage 2
        logic                  rst_s1;      // host reset stage 1
        logic                  rst_s2;      // host reset stage 2
        logic                  rem_s1;      // remote select stage 1
        logic                  rem_s2;      // remote select stage 2
        logic                  osc_s1;      // oscillator stage 1
        logic                  osc_s2;      // oscillator stage 2
        logic                  osc_d;       // oscillator delayed
        logic [1:0][7:0]       latch;       // channel control latches
        logic [1:0][15:0]      shift;       // trigger level shifters
        logic [1:0][9:0]       acc;         // rate multiplier phase
        logic [1:0]            rm_pulse;    // rate multiplier output
        logic [1:0]            rs_q;        // resync flip-flop
        ipi_chan_t [1:0]       chan;        // channel drive outputs
        logic [1:0][6:0]       relay;       // relay outputs
        logic                  oe_n;        // buffer enable
        logic                  lock;        // panel lockout
        logic                  mode;        // DAC mode output copy
        logic [1:0]            ctrl;        // software control
        logic                  pend;        // bus data phase pending
        logic                  pend_wr;     // pending is write
        logic [7:0]            pend_addr;   // pending byte address
        logic                  rdy;         // hreadyout
        logic [31:0]           rdata;       // hrdata
    } ipi_state_t;

    ipi_state_t st;                         // current state
    ipi_state_t next_st;                    // next state

    localparam logic [95:0] ROM_NDAC = `IPI_ROM_NDAC; // non-DAC decode
    localparam logic [95:0] ROM_DAC  = `IPI_ROM_DAC;  // DAC decode

    // decoder; the DAC bit is the upper address line
    function automatic ipi_word_t decode_char(input logic dac, input logic [3:0] code);
        logic [95:0] rom;
        rom = dac ? ROM_DAC : ROM_NDAC;                  // RULE13
        return ipi_word_t'(rom[code*`IPI_WORD_W +: `IPI_WORD_W]); // RULE9 RULE10
    endfunction : decode_char

    // bcd digits to a binary count 0..999
    function automatic logic [9:0] bcd_value(input logic [11:0] d);
        logic [9:0] v;
        v = 10'(d[11:8]) * `IPI_BCD_HUND;
        v = 10'(v + 10'(d[7:4]) * `IPI_BCD_TEN);
        return 10'(v + 10'(d[3:0]));
    endfunction : bcd_value

    logic             strb_rise;    // strobe rising edge
    logic             strb_fall;    // strobe falling edge
    logic             osc_rise;     // oscillator rising edge
    logic             osc_fall;     // oscillator falling edge
    logic             ch_ok;        // a single channel is selected
    logic             ch;           // selected channel index
    logic             in_dac;       // either channel holds DAC bit
    ipi_word_t        word;         // decoded character
    logic [10:0]      rm_sum;       // accumulator plus step
    logic [9:0]       rm_step;      // programmed pulses per period
    logic             bus_take;     // address phase accepted
    logic             clear_all;    // host or software reset

    // next state: synchronisers, interpreter, rate multipliers and bus slave
    always_comb begin
        next_st   = st;
        rm_sum    = 11'h000;
        rm_step   = 10'h000;

        // two-stage sync on every asynchronous pin; logic uses stage 2, plus a delayed copy for strobe and oscillator edges
        next_st.strb_s1 = char_strobe;
        next_st.strb_s2 = st.strb_s1;
        next_st.strb_d  = st.strb_s2;
        next_st.sel_s1  = {chan_sel_b, chan_sel_a};
        next_st.sel_s2  = st.sel_s1;
        next_st.code_s1 = char_code_nibble;
        next_st.code_s2 = st.code_s1;
        next_st.rst_s1  = interface_reset;
        next_st.rst_s2  = st.rst_s1;
        next_st.rem_s1  = remote_select_n;
        next_st.rem_s2  = st.rem_s1;
        next_st.osc_s1  = rm_osc;
        next_st.osc_s2  = st.osc_s1;
        next_st.osc_d   = st.osc_s2;

        // edges after sync; data is sampled two stages late as well,
        // so code and selects line up with the strobe edge
        strb_rise = st.strb_s2 & ~st.strb_d;          // RULE23
        strb_fall = ~st.strb_s2 & st.strb_d;          // RULE23
        osc_rise  = st.osc_s2 & ~st.osc_d;
        osc_fall  = ~st.osc_s2 & st.osc_d;

        // channel decode: A high and B low, or the reverse
        ch_ok = st.sel_s2[`IPI_CHAN_A] ^ st.sel_s2[`IPI_CHAN_B];   // RULE6
        ch    = st.sel_s2[`IPI_CHAN_B];                            // RULE6

        // mode line is the or of both channels' DAC bits
        in_dac = st.latch[`IPI_CHAN_A][`IPI_DAC_BIT] | st.latch[`IPI_CHAN_B][`IPI_DAC_BIT];
        word   = decode_char(in_dac, st.code_s2);

        clear_all = st.rst_s2 | st.ctrl[`IPI_CTRL_SRST];

        if (clear_all) begin
            // all latches low; DAC bit low means non-DAC mode
            next_st.latch = {NCH{`IPI_LATCH_RST}};    // RULE4 RULE8
        end else begin
            // non-DAC: rising edge clocks only the selected control latch
            if (strb_rise && ch_ok && !in_dac && !word.block) begin
                next_st.latch[ch][word.addr] = word.data; // RULE5 RULE12 RULE15 RULE22
            end
            // DAC mode: falling edge feeds the level shifter
            if (strb_fall && ch_ok && in_dac) begin
                if (!word.block) begin
                    next_st.shift[ch] = {st.shift[ch][11:0], st.code_s2}; // RULE14 RULE16
                end
                if (word.level_end) begin
                    next_st.latch[ch][`IPI_DAC_BIT] = 1'b0; // RULE17
                end
            end
            // in DAC mode the control latch bits below the mode bit
            // are never touched by the branches above
        end

        // sign and digits of each channel, held until reprogrammed
        for (int i = 0; i < NCH; i++) begin
            rm_step = bcd_value(st.shift[i][11:0]);   // RULE18
            if (osc_rise) begin
                if (st.ctrl[`IPI_CTRL_RUN]) begin
                    rm_sum = {1'b0, st.acc[i]} + {1'b0, rm_step};
                    // one carry per 1000 clocks for each unit of the count
                    if (rm_sum >= `IPI_RM_MOD) begin
                        next_st.acc[i]      = 10'(rm_sum - `IPI_RM_MOD); // RULE19
                        next_st.rm_pulse[i] = 1'b1;                      // RULE19
                    end else begin
                        next_st.acc[i]      = rm_sum[9:0];
                        next_st.rm_pulse[i] = 1'b0;
                    end
                end else begin
                    next_st.acc[i]      = 10'h000;
                    next_st.rm_pulse[i] = 1'b0;
                end
            end
            // resync on the opposite oscillator edge, mid-period
            if (osc_fall) begin
                next_st.rs_q[i] = st.rm_pulse[i];                 // RULE20
            end
            next_st.chan[i].pulse_q   = st.rs_q[i];               // RULE20
            next_st.chan[i].pulse_q_n = ~st.rs_q[i];              // RULE20
            // plus turns off the positive source, on the negative one
            next_st.chan[i].pos_src_en =
                (st.shift[i][`IPI_SIGN_HI:`IPI_SIGN_LO] != `IPI_CODE_PLUS); // RULE21
            next_st.chan[i].neg_src_en =
                (st.shift[i][`IPI_SIGN_HI:`IPI_SIGN_LO] == `IPI_CODE_PLUS); // RULE21
            next_st.relay[i] = st.latch[i][6:0];
        end

        // remote low: panel locked out, latch buffers drive the relays
        next_st.lock = ~st.rem_s2;                    // RULE1
        next_st.oe_n = st.rem_s2;                     // RULE2
        next_st.mode = in_dac;

        // software reset is a single-cycle pulse
        next_st.ctrl[`IPI_CTRL_SRST] = 1'b0;

        // bus: address phase taken, one wait state, then data phase ends
        bus_take = hsel & htrans[1] & hready;
        if (st.pend) begin
            next_st.pend = 1'b0;
            next_st.rdy  = 1'b1;
            next_st.rdata = 32'h0000_0000;
            if (st.pend_wr) begin
                // only the control word is writable
                if (st.pend_addr == `IPI_REG_CTRL) begin
                    next_st.ctrl = hwdata[1:0];
                end
            end else begin
                case (st.pend_addr)
                    `IPI_REG_CTRL: begin
                        next_st.rdata = {30'h0000_0000, st.ctrl};
                    end
                    `IPI_REG_STATUS: begin
                        next_st.rdata = {28'h000_0000, st.rst_s2, ~st.rem_s2,
                                         st.latch[`IPI_CHAN_B][`IPI_DAC_BIT],
                                         st.latch[`IPI_CHAN_A][`IPI_DAC_BIT]};
                    end
                    `IPI_REG_LATCH: begin
                        next_st.rdata = {16'h0000, st.latch[`IPI_CHAN_B], st.latch[`IPI_CHAN_A]};
                    end
                    `IPI_REG_LEVEL_A: begin
                        next_st.rdata = {16'h0000, st.shift[`IPI_CHAN_A]};
                    end
                    `IPI_REG_LEVEL_B: begin
                        next_st.rdata = {16'h0000, st.shift[`IPI_CHAN_B]};
                    end
                    default: begin
                        // unmapped reads as zero, still okay
                        next_st.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end else if (bus_take) begin
            next_st.pend      = 1'b1;
            next_st.pend_wr   = hwrite;
            next_st.pend_addr = haddr[7:0];
            next_st.rdy       = 1'b0;
        end else begin
            next_st.rdy = 1'b1;
        end
    end

    // state register; async reset loads constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st           <= '0;
            st.latch     <= {NCH{`IPI_LATCH_RST}};        // RULE4
            st.shift     <= {NCH{`IPI_SHIFT_RST}};
            st.rem_s1    <= 1'b1;
            st.rem_s2    <= 1'b1;
            st.oe_n      <= 1'b1;
            st.ctrl      <= `IPI_CTRL_RST;
            st.rdy       <= 1'b1;
            for (int i = 0; i < NCH; i++) begin
                st.chan[i].pos_src_en <= 1'b1;
                st.chan[i].pulse_q_n  <= 1'b1;
            end
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops, except hresp tied low
    assign hreadyout        = st.rdy;
    assign hresp            = 1'b0;
    assign hrdata           = st.rdata;
    assign local_sw_disable = st.lock;
    assign relay_oe_n       = st.oe_n;
    assign relay_ctrl       = st.relay;
    assign dac_mode         = st.mode;
    assign dac_out          = st.chan;

endmodule : ipi_input_prog

//--- ipi_input_prog_assertions.sv
// port-level checker for the input program interface
`timescale 1ns/1ns
`include "ipi_consts.svh"

module ipi_input_prog_assertions (
    input wire logic                     hclk,             // bus clock
    input wire logic                     hresetn,          // async reset, low
    input wire logic                     remote_select_n,  // remote, low
    input wire logic                     interface_reset,  // host clear
    input wire logic                     char_strobe,      // character clock
    input wire logic                     chan_sel_a,       // channel A select
    input wire logic                     chan_sel_b,       // channel B select
    input wire logic [3:0]               char_code_nibble, // character code
    input wire logic                     local_sw_disable, // panel lockout
    input wire logic                     relay_oe_n,       // relay enable, low
    input wire logic [1:0][6:0]          relay_ctrl,       // relay drive
    input wire logic                     dac_mode,         // level load mode
    input wire ipi_pkg::ipi_chan_t [1:0] dac_out           // level drive
);
    import ipi_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // strobe rise on one selected channel outside level loading
    sequence s_ndac_rise;
        $rose(char_strobe) && !dac_mode && !interface_reset && (chan_sel_a != chan_sel_b);
    endsequence
    // asterisk strobe falling while a level loads
    sequence s_star_fall;
        $fell(char_strobe) && dac_mode && char_code_nibble == `IPI_CODE_STAR;
    endsequence
    // margins cover the pin synchronisers, which add up to two cycles
    a_panel_lockout: assert property ($fell(remote_select_n) |-> ##[1:5] local_sw_disable)
        else $error("panel switches not locked out");
    a_relay_drive: assert property (!remote_select_n [*6] |-> !relay_oe_n)
        else $error("relay buffers not enabled in remote");
    a_relay_idle: assert property (remote_select_n [*6] |-> relay_oe_n)
        else $error("relay buffers enabled in local");
    a_host_clear: assert property (interface_reset [*5] |-> relay_ctrl == '0 && !dac_mode)
        else $error("host clear left latches set");
    a_sign_enters: assert property (s_ndac_rise ##0 (char_code_nibble == `IPI_CODE_PLUS
        || char_code_nibble == `IPI_CODE_MINUS) |-> ##[3:7] dac_mode)
        else $error("sign did not enter level mode");
    a_decode_seven: assert property (s_ndac_rise ##0 char_code_nibble == 4'h7
        |-> ##[3:7] relay_ctrl[chan_sel_b][1])
        else $error("code seven did not set its latch bit");
    a_star_exits: assert property (s_star_fall |-> ##[3:7] !dac_mode)
        else $error("asterisk did not leave level mode");
    a_latch_frozen: assert property (dac_mode && $past(dac_mode) |-> relay_ctrl == $past(relay_ctrl))
        else $error("control latch moved during level load");
    a_sign_held: assert property (!dac_mode [*4] |-> $stable(dac_out[0].pos_src_en)
        && $stable(dac_out[1].pos_src_en))
        else $error("stored sign changed outside level load");
    a_source_select: assert property ((dac_out[0].pos_src_en != dac_out[0].neg_src_en)
        && (dac_out[1].pos_src_en != dac_out[1].neg_src_en))
        else $error("both or neither current source enabled");
    a_pulse_pair: assert property (dac_out[0].pulse_q_n == !dac_out[0].pulse_q
        && dac_out[1].pulse_q_n == !dac_out[1].pulse_q)
        else $error("pulse outputs not complementary");
endmodule : ipi_input_prog_assertions

bind ipi_input_prog ipi_input_prog_assertions i_chk (.hclk(hclk), .hresetn(hresetn),
    .remote_select_n(remote_select_n), .interface_reset(interface_reset), .char_strobe(char_strobe),
    .chan_sel_a(chan_sel_a), .chan_sel_b(chan_sel_b), .char_code_nibble(char_code_nibble),
    .local_sw_disable(local_sw_disable), .relay_oe_n(relay_oe_n), .relay_ctrl(relay_ctrl),
    .dac_mode(dac_mode), .dac_out(dac_out));

//--- ipi_host_model.sv
// host board model driving characters onto the character link
`timescale 1ns/1ns

module ipi_host_model (
    output logic       remote_select_n,  // remote, low
    output logic       interface_reset,  // host clear, high
    output logic       char_strobe,      // character clock
    output logic       chan_sel_a,       // channel A select
    output logic       chan_sel_b,       // channel B select
    output logic [3:0] char_code_nibble  // character code
);
    // idle link: local mode, strobe parked low, nothing selected
    initial begin
        remote_select_n  = 1'b1;
        interface_reset  = 1'b0;
        char_strobe      = 1'b0;
        {chan_sel_b, chan_sel_a} = 2'b00;
        char_code_nibble = 4'h5;
    end
    // one character, 800 ns; selects stay put until the next prefix
    task send(input logic [1:0] ch, input logic [3:0] code);
        {chan_sel_b, chan_sel_a} <= ch;
        char_code_nibble <= code;
        #100 char_strobe <= 1'b1;
        #400 char_strobe <= 1'b0;
        #300 char_code_nibble <= ~code; // released lines must not look valid
    endtask : send
    // clear pulse, as raised on the reset character
    task clear();
        interface_reset <= 1'b1;
        #1000 interface_reset <= 1'b0;
    endtask : clear
    // remote or local mode
    task remote(input logic v);
        remote_select_n <= v;
    endtask : remote
endmodule : ipi_host_model

//--- test_ipi_input_prog.sv
// self-checking bench for the input program interface
`timescale 1ns/1ns
`include "ipi_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module test_ipi_input_prog;
    import ipi_pkg::*;
    logic            hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rm_osc;  // bus and osc
    logic [31:0]     haddr, hwdata, hrdata, rd;        // bus data
    logic [1:0]      htrans;                           // transfer type
    logic [2:0]      hsize;                            // word size
    wire logic       remote_select_n, interface_reset, char_strobe, chan_sel_a, chan_sel_b;
    wire logic [3:0] char_code_nibble;                 // character code
    logic            local_sw_disable, relay_oe_n, dac_mode;
    logic [1:0][6:0] relay_ctrl;                       // relay drive
    ipi_chan_t [1:0] dac_out;                          // level drive
    int              errors, compares, pulses0, pulses1, base0, base1;
    // digit decode words {end,block,addr,data}
    localparam logic [5:0] dec_word [10] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
                                             6'h09, 6'h02, 6'h03, 6'h0A, 6'h0B};

    assign hready = hreadyout;
    ipi_input_prog i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .remote_select_n(remote_select_n), .interface_reset(interface_reset),
        .char_strobe(char_strobe), .chan_sel_a(chan_sel_a), .chan_sel_b(chan_sel_b),
        .char_code_nibble(char_code_nibble), .rm_osc(rm_osc), .local_sw_disable(local_sw_disable),
        .relay_oe_n(relay_oe_n), .relay_ctrl(relay_ctrl), .dac_mode(dac_mode), .dac_out(dac_out));
    ipi_host_model i_host (.remote_select_n(remote_select_n), .interface_reset(interface_reset),
        .char_strobe(char_strobe), .chan_sel_a(chan_sel_a), .chan_sel_b(chan_sel_b),
        .char_code_nibble(char_code_nibble));

    // 10 MHz bus clock
    always #50 hclk = ~hclk;
    // free oscillator, 800 ns, off the bus clock phase
    initial begin
        rm_osc = 1'b0;
        #37;
        forever #400 rm_osc = ~rm_osc;
    end
    // pulse output sampled 200 ns after each oscillator rise, so back-to-back pulses each count
    always @(posedge rm_osc) begin
        #200;
        if (dac_out[0].pulse_q === 1'b1) pulses0++;
        if (dac_out[1].pulse_q === 1'b1) pulses1++;
    end

    // verdict and end of run
    task report_and_stop;
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // wait for hready, bounded
    task wait_ready;
        int n;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin errors++; report_and_stop(); end
    endtask : wait_ready
    // one single word transfer; read data lands in rd
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= a; hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : bus
    // a character, then time for synchronisers and latches
    task chr(input logic [1:0] ch, input logic [3:0] c);
        i_host.send(ch, c);
        repeat (6) @(posedge hclk);
    endtask : chr
    // prefix held, sign, X . Y Z, asterisk
    task level(input logic [1:0] ch, input logic [3:0] s, input logic [3:0] x);
        chr(ch, s); `CHK(dac_mode, 1'b1)
        bus(0, `IPI_REG_STATUS, 0); `CHK(rd, {28'h0, 2'b01, ch})
        chr(ch, x); chr(ch, `IPI_CODE_POINT); chr(ch, x); chr(ch, x);
        chr(ch, `IPI_CODE_STAR); `CHK(dac_mode, 1'b0)
    endtask : level

    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0;
        haddr = 32'h0; hsize = 3'b010; hwdata = 32'h0;
        errors = 0; compares = 0; pulses0 = 0; pulses1 = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK(relay_ctrl, 14'h0)
        `CHK(dac_out[0], 4'h9)
        `CHK(hresp, 1'b0)
        bus(0, `IPI_REG_CTRL, 0); `CHK(rd, 32'h1)
        bus(0, `IPI_REG_LATCH, 0); `CHK(rd, 32'h0)
        bus(0, 32'h40, 0); `CHK(rd, 32'h0)
        bus(1, `IPI_REG_STATUS, 32'hF); bus(0, `IPI_REG_STATUS, 0); `CHK(rd, 32'h0)
        i_host.remote(1'b0);
        repeat (6) @(posedge hclk);
        `CHK(local_sw_disable, 1'b1)
        `CHK(relay_oe_n, 1'b0)
        // every digit on channel A, each decoded word checked at its bit
        for (int c = 0; c < 10; c++) begin
            chr(2'b01, c[3:0]);
            `CHK(relay_ctrl[0][dec_word[c][3:1]], dec_word[c][0])
        end
        `CHK(relay_ctrl, {7'h00, 7'h3E})
        chr(2'b10, 4'h7); chr(2'b00, 4'h5); chr(2'b11, 4'h5);
        `CHK(relay_ctrl, {7'h02, 7'h3E})
        level(2'b01, `IPI_CODE_PLUS, 4'h2);
        level(2'b10, `IPI_CODE_MINUS, 4'h9);
        `CHK(relay_ctrl, {7'h02, 7'h3E})
        bus(0, `IPI_REG_LEVEL_A, 0); `CHK(rd, 32'hB222)
        bus(0, `IPI_REG_LEVEL_B, 0); `CHK(rd, 32'hD999)
        bus(0, `IPI_REG_LATCH, 0); `CHK(rd, 32'h023E)
        `CHK({dac_out[0][3:2], dac_out[1][3:2]}, 4'b0110)
        // window aligned off the sample point: exactly 1000 samples counted
        @(posedge rm_osc);
        #300;
        base0 = pulses0;
        base1 = pulses1;
        repeat (1000) @(posedge rm_osc);
        #300;
        `CHK(pulses0 - base0, 222)
        `CHK(pulses1 - base1, 999)
        @(posedge hclk);
        bus(1, `IPI_REG_CTRL, 32'h3);
        repeat (3) @(posedge hclk);
        `CHK(relay_ctrl, 14'h0)
        bus(0, `IPI_REG_CTRL, 0); `CHK(rd, 32'h1)
        chr(2'b01, 4'h7); `CHK(relay_ctrl[0], 7'h02)
        i_host.clear();
        repeat (6) @(posedge hclk);
        `CHK(relay_ctrl, 14'h0)
        bus(0, `IPI_REG_LEVEL_A, 0); `CHK(rd, 32'hB222)
        i_host.remote(1'b1);
        repeat (6) @(posedge hclk);
        `CHK(relay_oe_n, 1'b1)
        report_and_stop();
    end
endmodule : test_ipi_input_prog
